// ### logic/pps_top.sv
// Port pin steering block: AXI4-Lite registers, latch, direction and pin routing
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"

module pps_top (
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	// AXI4-Lite slave
	input  wire logic [11:0]              s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [11:0]              s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Pins
	input  wire logic [5:0]               pin_in,
	output pps_pkg::pps_pin_drive_t       pin_drive,
	// Peripherals
	input  wire pps_pkg::pps_periph_out_t periph_out,
	output pps_pkg::pps_periph_in_t       periph_in
);
	import pps_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0]     alt_sel_q;
	logic [5:0]     lat_q;
	logic [5:0]     dir_q;
	logic [5:0]     ana_q;
	logic [5:0]     wpu_q;
	logic [5:0]     pin_q;
	pps_bus_state_t wst_q;
	pps_bus_state_t rst_q;
	logic           aw_got_q;
	logic           w_got_q;
	logic [11:0]    awaddr_q;
	logic [31:0]    wdata_q;
	logic [3:0]     wstrb_q;
	logic [1:0]     bresp_q;
	logic [31:0]    rdata_q;
	logic [1:0]     rresp_q;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [3:0] reg_index(input logic [11:0] a);
		if (a == `PPS_OFF_ALT_SEL)
			return 4'h1;
		else if (a == `PPS_OFF_VALUE)
			return 4'h2;
		else if (a == `PPS_OFF_LATCH)
			return 4'h3;
		else if (a == `PPS_OFF_DIR)
			return 4'h4;
		else if (a == `PPS_OFF_ANALOG)
			return 4'h5;
		else if (a == `PPS_OFF_PULLUP)
			return 4'h6;
		else if (a == `PPS_OFF_PERIPH_EN)
			return 4'h7;
		else if (a == `PPS_OFF_PERIPH_IN)
			return 4'h8;
		else
			return 4'h0;
	endfunction

	// ----------------------------------------------------------------
	// Digital input path
	// ----------------------------------------------------------------
	// Analog pins have their input buffer gated off, so they read as zero
	wire [5:0] pin_digital = pin_q & ~ana_q;

	logic [5:0]     rt_out;
	logic [5:0]     rt_oe;
	pps_periph_in_t rt_in;

	pps_route u_route (
		.sel         (alt_sel_q),
		.lat         (lat_q),
		.dir         (dir_q),
		.pin_digital (pin_digital),
		.po          (periph_out),
		.pin_out     (rt_out),
		.pin_oe      (rt_oe),
		.pi          (rt_in)
	);

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	wire        aw_fire  = s_axi_awvalid && s_axi_awready;
	wire        w_fire   = s_axi_wvalid && s_axi_wready;
	wire        aw_have  = aw_got_q || aw_fire;
	wire        w_have   = w_got_q || w_fire;
	wire [11:0] wa       = aw_got_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wd       = w_got_q ? wdata_q : s_axi_wdata;
	wire [3:0]  ws       = w_got_q ? wstrb_q : s_axi_wstrb;
	wire        do_write = (wst_q == PPS_IDLE) && aw_have && w_have;
	wire [3:0]  widx     = reg_index(wa);
	wire        wlane0   = do_write && ws[0];
	wire        wr_bad   = (widx == 4'h0) || (widx == 4'h8);

	// Handshake capture; address and data may arrive in either order
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
			end
		end
	end

	// Response state; ready is held low while a response is pending
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wst_q         <= PPS_IDLE;
			bresp_q       <= `PPS_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			case (wst_q)
				PPS_IDLE: begin
					s_axi_awready <= !aw_have;
					s_axi_wready  <= !w_have;
					if (do_write) begin
						wst_q         <= PPS_RESP;
						bresp_q       <= wr_bad ? `PPS_RESP_SLVERR : `PPS_RESP_OKAY;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
					end
				end
				default: begin
					if (s_axi_bready) begin
						wst_q <= PPS_IDLE;
					end
				end
			endcase
		end
	end

	assign s_axi_bvalid = (wst_q == PPS_RESP);
	assign s_axi_bresp  = bresp_q;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Port value and latch writes share one latch; selection never touches direction
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			alt_sel_q <= `PPS_RST_ALT_SEL;
			lat_q     <= `PPS_RST_LATCH;
			dir_q     <= `PPS_RST_DIR;
			ana_q     <= `PPS_RST_ANALOG;
			wpu_q     <= `PPS_RST_PULLUP;
		end else if (wlane0) begin
			if (widx == 4'h1)
				alt_sel_q <= wd[7:0] & `PPS_SEL_MASK;
			else if (widx == 4'h2 || widx == 4'h3)
				lat_q <= wd[5:0];
			else if (widx == 4'h4)
				dir_q <= wd[5:0] | 6'h08;
			else if (widx == 4'h5)
				ana_q <= wd[5:0];
			else if (widx == 4'h6)
				wpu_q <= wd[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	wire       ar_fire = s_axi_arvalid && s_axi_arready;
	wire [3:0] ridx    = reg_index(s_axi_araddr);
	wire [10:0] en_vec = {periph_out.uart_tx_en, periph_out.uart_tx_oe,
		periph_out.uart_rx_oe, periph_out.spi_out_en, periph_out.pwm_b_en,
		periph_out.cap_pwm_a_en, 5'h00};
	wire [31:0] rd_mux =
		(ridx == 4'h1) ? {24'h000000, alt_sel_q} :
		(ridx == 4'h2) ? {26'h0000000, pin_digital} :
		(ridx == 4'h3) ? {26'h0000000, lat_q} :
		(ridx == 4'h4) ? {26'h0000000, dir_q} :
		(ridx == 4'h5) ? {26'h0000000, ana_q} :
		(ridx == 4'h6) ? {26'h0000000, wpu_q} :
		(ridx == 4'h7) ? {21'h000000, en_vec} :
		(ridx == 4'h8) ? {27'h0000000, rt_in} : 32'h0000_0000;

	// Single-entry read; arready held off until the data is taken
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rst_q         <= PPS_IDLE;
			s_axi_arready <= 1'b0;
			rdata_q       <= 32'h0000_0000;
			rresp_q       <= `PPS_RESP_OKAY;
		end else begin
			case (rst_q)
				PPS_IDLE: begin
					s_axi_arready <= !ar_fire;
					if (ar_fire) begin
						rst_q   <= PPS_RESP;
						rdata_q <= rd_mux;
						rresp_q <= (ridx == 4'h0) ? `PPS_RESP_SLVERR : `PPS_RESP_OKAY;
					end
				end
				default: begin
					if (s_axi_rready) begin
						rst_q         <= PPS_IDLE;
						s_axi_arready <= 1'b1;
					end
				end
			endcase
		end
	end

	assign s_axi_rvalid = (rst_q == PPS_RESP);
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// ----------------------------------------------------------------
	// Pin sampling and registered pin and peripheral outputs
	// ----------------------------------------------------------------
	// Pins sampled once so reads and routing see one consistent value
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_q             <= 6'h00;
			pin_drive.out     <= 6'h00;
			pin_drive.oe      <= 6'h00;
			pin_drive.pull_up <= 6'h00;
			periph_in         <= '0;
		end else begin
			pin_q             <= pin_in;
			pin_drive.out     <= rt_out;
			pin_drive.oe      <= rt_oe;
			pin_drive.pull_up <= wpu_q & dir_q;
			periph_in         <= rt_in;
		end
	end

endmodule
`default_nettype wire

// ### pkg/pps_cfg.svh
// Register offsets, field positions and reset values of the port pin steering block
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPS_OFF_ALT_SEL   12'h000
`define PPS_OFF_VALUE     12'h004
`define PPS_OFF_LATCH     12'h008
`define PPS_OFF_DIR       12'h00C
`define PPS_OFF_ANALOG    12'h010
`define PPS_OFF_PULLUP    12'h014
`define PPS_OFF_PERIPH_EN 12'h018
`define PPS_OFF_PERIPH_IN 12'h01C

// ----------------------------------------------------------------
// Selection field positions
// ----------------------------------------------------------------
`define PPS_SEL_UART_RX   7
`define PPS_SEL_SPI_OUT   6
`define PPS_SEL_SLAVE_SEL 5
`define PPS_SEL_TIMER_GT  3
`define PPS_SEL_UART_TX   2
`define PPS_SEL_PWM_B     1
`define PPS_SEL_CAP_PWM_A 0
`define PPS_SEL_MASK      8'hEF

// ----------------------------------------------------------------
// Reset values and the input-only pin
// ----------------------------------------------------------------
`define PPS_RST_ALT_SEL   8'h00
`define PPS_RST_DIR       6'h3F
`define PPS_RST_LATCH     6'h00
`define PPS_RST_ANALOG    6'h3F
`define PPS_RST_PULLUP    6'h00
`define PPS_INPUT_ONLY    3

// ----------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------
`define PPS_RESP_OKAY     2'h0
`define PPS_RESP_SLVERR   2'h2

`endif

// ### pkg/pps_pkg.sv
// Types shared by the port pin steering block
package pps_pkg;

	// Peripheral side of the steered functions, outputs and enables
	typedef struct packed {
		logic uart_tx_en;    // Transmitter owns its pin
		logic uart_tx_out;
		logic uart_tx_oe;    // Synchronous clock mode drives the pin
		logic uart_rx_oe;    // Synchronous data mode drives the pin
		logic uart_rx_out;
		logic spi_out_en;
		logic spi_out;
		logic pwm_b_en;
		logic pwm_b;
		logic cap_pwm_a_en;
		logic cap_pwm_a;
	} pps_periph_out_t;

	// Inputs delivered back to the peripherals
	typedef struct packed {
		logic uart_rx;
		logic uart_tx_clk;
		logic slave_select;
		logic timer_gate;
		logic cap_in;
	} pps_periph_in_t;

	// Pin driver group: output, enable, pull-up
	typedef struct packed {
		logic [5:0] out;
		logic [5:0] oe;
		logic [5:0] pull_up;
	} pps_pin_drive_t;

	typedef enum logic [1:0] {
		PPS_IDLE,
		PPS_RESP
	} pps_bus_state_t;

endpackage

// ### logic/pps_route.sv
// Combinational steering of peripheral functions onto the six port pins
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"

module pps_route (
	input  wire logic [7:0]              sel,
	input  wire logic [5:0]              lat,
	input  wire logic [5:0]              dir,
	input  wire logic [5:0]              pin_digital,
	input  wire pps_pkg::pps_periph_out_t po,
	output logic [5:0]                   pin_out,
	output logic [5:0]                   pin_oe,
	output pps_pkg::pps_periph_in_t      pi
);
	import pps_pkg::*;

	// ----------------------------------------------------------------
	// Pin choice per function
	// ----------------------------------------------------------------
	wire rx_hi  = sel[`PPS_SEL_UART_RX];
	wire tx_hi  = sel[`PPS_SEL_UART_TX];
	wire sdo_hi = sel[`PPS_SEL_SPI_OUT];
	wire ss_hi  = sel[`PPS_SEL_SLAVE_SEL];
	wire tg_hi  = sel[`PPS_SEL_TIMER_GT];
	wire pb_hi  = sel[`PPS_SEL_PWM_B];
	wire pa_hi  = sel[`PPS_SEL_CAP_PWM_A];

	// One-hot pin masks, built once so the driver mux reads them only
	wire [5:0] rx_pin  = rx_hi  ? 6'h20 : 6'h02;
	wire [5:0] tx_pin  = tx_hi  ? 6'h10 : 6'h01;
	wire [5:0] sdo_pin = sdo_hi ? 6'h10 : 6'h01;
	wire [5:0] pb_pin  = pb_hi  ? 6'h10 : 6'h01;
	wire [5:0] pa_pin  = pa_hi  ? 6'h20 : 6'h04;

	// ----------------------------------------------------------------
	// Output ownership, lowest priority applied first
	// ----------------------------------------------------------------
	// Only the chosen pin sees an override; the other keeps latch and direction
	always_comb begin
		pin_out = lat;
		pin_oe  = ~dir;
		for (int i = 0; i < 6; i++) begin
			if (pa_pin[i] && po.cap_pwm_a_en) begin
				pin_out[i] = po.cap_pwm_a;
				pin_oe[i]  = ~dir[i];
			end
			if (rx_pin[i] && po.uart_rx_oe) begin
				pin_out[i] = po.uart_rx_out;
				pin_oe[i]  = 1'b1;
			end
			if (pb_pin[i] && po.pwm_b_en) begin
				pin_out[i] = po.pwm_b;
				pin_oe[i]  = ~dir[i];
			end
			if (sdo_pin[i] && po.spi_out_en) begin
				pin_out[i] = po.spi_out;
				pin_oe[i]  = ~dir[i];
			end
			if (tx_pin[i] && (po.uart_tx_en || po.uart_tx_oe)) begin
				pin_out[i] = po.uart_tx_out;
				pin_oe[i]  = 1'b1;
			end
		end
		pin_out[`PPS_INPUT_ONLY] = 1'b0;
		pin_oe[`PPS_INPUT_ONLY]  = 1'b0;
	end

	// ----------------------------------------------------------------
	// Input routing from the chosen pin
	// ----------------------------------------------------------------
	assign pi.uart_rx      = rx_hi ? pin_digital[5] : pin_digital[1];
	assign pi.uart_tx_clk  = tx_hi ? pin_digital[4] : pin_digital[0];
	assign pi.slave_select = ss_hi ? pin_digital[0] : pin_digital[3];
	assign pi.timer_gate   = tg_hi ? pin_digital[3] : pin_digital[4];
	assign pi.cap_in       = pa_hi ? pin_digital[5] : pin_digital[2];

endmodule
`default_nettype wire

// ### tb/pps_top_asserts.sv
// Bus handshake and pin ownership checks for the steering block top
`timescale 1ns/1ps
`default_nettype none

module pps_top_chk (
	input wire logic                    sys_clk,
	input wire logic                    resetn,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire pps_pkg::pps_pin_drive_t  pin_drive,
	input wire pps_pkg::pps_periph_out_t periph_out
);
	import pps_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Both write halves taken at one edge
	sequence wr_taken_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Transmitter held on long enough to pass the pin register
	sequence tx_held_s;
		(periph_out.uart_tx_en && periph_out.uart_tx_oe) [*3];
	endsequence
	// Transmitter held high, so its level must show on one of its two pins
	sequence tx_high_s;
		(periph_out.uart_tx_en && periph_out.uart_tx_oe && periph_out.uart_tx_out) [*3];
	endsequence

	wr_resp_a:
		assert property (wr_taken_s |=> s_axi_bvalid) else $error("no write response");
	rd_resp_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	bresp_hold_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	rdata_hold_a:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	resp_drop_a:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response kept after accept");
	write_block_a:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	read_block_a:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted twice");
	input_pin_a:
		assert property (pin_drive.oe[3] == 1'b0) else $error("input only pin driven");
	tx_owns_pin_a:
		assert property (tx_held_s |-> pin_drive.oe[0] || pin_drive.oe[4])
		else $error("transmitter pin not driven");
	tx_level_a:
		assert property (tx_high_s |-> (pin_drive.oe[0] && pin_drive.out[0]) ||
			(pin_drive.oe[4] && pin_drive.out[4]))
		else $error("transmitter level not on its pin");
endmodule

bind pps_top pps_top_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pin_drive(pin_drive), .periph_out(periph_out));
`default_nettype wire

// ### tb/pps_board.sv
// Board circuitry model on the six port pins
`timescale 1ns/1ps
`default_nettype none

module pps_board (
	input  wire logic                    sys_clk,
	input  wire pps_pkg::pps_pin_drive_t drv,
	input  wire logic [5:0]              ext_en,
	input  wire logic [5:0]              ext_val,
	output logic [5:0]                   pin_in
);
	import pps_pkg::*;
	logic [5:0] float_q;

	// Undriven pins wander so a stale level never passes for a driven one
	always_ff @(posedge sys_clk) begin
		float_q <= ~pin_in;
	end

	// Device driver first, then board source, then pull-up
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin_in[i] = drv.oe[i] ? drv.out[i] : ext_en[i] ? ext_val[i] :
				drv.pull_up[i] ? 1'b1 : float_q[i];
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench of the port pin steering block
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	import pps_pkg::*;
	localparam logic [1:0] OK = `PPS_RESP_OKAY;
	localparam logic [1:0] ER = `PPS_RESP_SLVERR;
	logic             sys_clk = 0, resetn = 0;
	logic [11:0]      awaddr = 0, araddr = 0;
	logic [31:0]      wdata = 0, rdata;
	logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp;
	logic [5:0]       pin_in, ext_en = 6'h3F, ext_val = 6'h00;
	pps_pin_drive_t   pin_drive;
	pps_periph_out_t  periph_out = '0;
	pps_periph_in_t   periph_in;
	int               num_errors = 0, num_checks = 0, cycles = 0;
	// Steered outputs: select bit, pin when set, pin when clear, stimulus
	int               obit[4] = '{2, 6, 1, 0};
	int               oset[4] = '{4, 4, 4, 5};
	int               oclr[4] = '{0, 0, 0, 2};
	logic [10:0]      opat[4] = '{11'h700, 11'h030, 11'h00C, 11'h003};
	// Enable bits each stimulus shows in the peripheral enable register
	logic [31:0]      oen[4] = '{32'h600, 32'h080, 32'h040, 32'h020};
	// Steered inputs: select bit, pins, field position in periph_in
	int               ibit[5] = '{7, 2, 5, 3, 0};
	int               iset[5] = '{5, 4, 0, 3, 5};
	int               iclr[5] = '{1, 0, 3, 4, 2};
	int               iidx[5] = '{4, 3, 2, 1, 0};

	pps_top dut (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_drive(pin_drive),
		.periph_out(periph_out), .periph_in(periph_in));
	pps_board board (.sys_clk(sys_clk), .drv(pin_drive), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	always #5 sys_clk = ~sys_clk;

	// A hang is cut short well past the expected run length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Write: both halves offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask

	// Read: data only compared on a good response
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		`CHK("rresp", er, rresp)
		if (er == OK) `CHK("rdata", e, rdata)
	endtask

	// Pin path crosses the pin register and the input register
	task automatic settle();
		repeat (4) @(posedge sys_clk);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(`PPS_OFF_ALT_SEL, 32'h0, OK);
		rd(`PPS_OFF_DIR, 32'h3F, OK);
		rd(`PPS_OFF_LATCH, 32'h0, OK);
		rd(`PPS_OFF_ANALOG, 32'h3F, OK);
		wr(`PPS_OFF_ALT_SEL, 32'hFF, OK);
		rd(`PPS_OFF_ALT_SEL, 32'hEF, OK);
		rd(`PPS_OFF_DIR, 32'h3F, OK);
		wr(`PPS_OFF_VALUE, 32'h15, OK);
		rd(`PPS_OFF_LATCH, 32'h15, OK);
		wr(`PPS_OFF_LATCH, 32'h2A, OK);
		wr(`PPS_OFF_ANALOG, 32'h0, OK);
		wr(`PPS_OFF_DIR, 32'h0, OK);
		rd(`PPS_OFF_DIR, 32'h08, OK);
		settle();
		`CHK("oe", 6'h37, pin_drive.oe)
		`CHK("out", 6'h22, pin_drive.out & 6'h37)
		rd(`PPS_OFF_VALUE, 32'h22, OK);
		rd(`PPS_OFF_LATCH, 32'h2A, OK);
		wr(`PPS_OFF_ANALOG, 32'h3F, OK);
		settle();
		rd(`PPS_OFF_VALUE, 32'h0, OK);
		`CHK("oe", 6'h37, pin_drive.oe)
		wr(`PPS_OFF_ANALOG, 32'h0, OK);
		wr(`PPS_OFF_LATCH, 32'h0, OK);
		for (int i = 0; i < 4; i++) begin
			for (int s = 0; s < 2; s++) begin
				periph_out <= pps_periph_out_t'(opat[i]);
				wr(`PPS_OFF_ALT_SEL, s ? (32'h1 << obit[i]) : 32'h0, OK);
				settle();
				`CHK("out", 6'h1 << (s ? oset[i] : oclr[i]), pin_drive.out)
			end
			rd(`PPS_OFF_PERIPH_EN, oen[i], OK);
		end
		periph_out <= '0;
		wr(`PPS_OFF_DIR, 32'h3F, OK);
		// Pull-ups only act on pins whose direction bit is set
		wr(`PPS_OFF_PULLUP, 32'h15, OK);
		rd(`PPS_OFF_PULLUP, 32'h15, OK);
		for (int i = 0; i < 5; i++) begin
			ext_val <= 6'h1 << iset[i];
			for (int s = 0; s < 2; s++) begin
				wr(`PPS_OFF_ALT_SEL, s ? (32'h1 << ibit[i]) : 32'h0, OK);
				settle();
				`CHK("in", (s != 0), periph_in[iidx[i]])
				if (i == 0) rd(`PPS_OFF_PERIPH_IN, s ? 32'h10 : 32'h0, OK);
			end
		end
		rd(`PPS_OFF_DIR, 32'h3F, OK);
		`CHK("pull_up", 6'h15, pin_drive.pull_up)
		wr(`PPS_OFF_DIR, 32'h0, OK);
		settle();
		`CHK("pull_up", 6'h00, pin_drive.pull_up)
		rd(12'h020, 32'h0, ER);
		wr(`PPS_OFF_PERIPH_IN, 32'h1, ER);
		report_and_stop();
	end
endmodule
`default_nettype wire
